// ### core/dcr_core.sv
// decoder control register set with converter clock divider
`timescale 1ns/1ps

// How it works
// - second data memory readable, 20-bit words returned
// - default read returns frame counter immediately
// - writes to unknown numbers accepted, no effect
// - converter word write-only at 8e, reset 08000
// - mute/bypass register read/write, resets zero
// - pin level live in bit zero
// - boot setting shadow mirrors straps or writes
// - prescale coefficient read/write, resets 80000
// - low shelf coefficient read/write, resets zero
// - high shelf coefficient read/write, resets zero
// - commands served only while both enables high
// - converter word kept while enables low
// - supply level field selects target, power good
// - clock select field picks switching frequency
// - converter clock is reference over 2(32+n)
// - write register stores 20-bit value
// - bit zero mutes output, decoding continues
// - bit one bypasses tone stage
module dcr_core (
    // clock and reset
    input wire logic i_clock,
    input wire logic i_rst_b,
    // decoded command requests
    input wire logic i_req_valid,
    input wire logic [3:0] i_req_kind,
    input wire logic [7:0] i_req_reg,
    input wire logic [10:0] i_req_mem_addr,
    input wire logic [19:0] i_req_data,
    output logic o_ready,
    output logic o_rsp_valid,
    output logic [19:0] o_rsp_data,
    // second data memory read port
    output logic o_mem_rd,
    output logic [10:0] o_mem_addr,
    input wire logic [19:0] i_mem_data,
    // decoder status, same clock
    input wire logic [15:0] i_frame_count,
    // pins from outside the clock domain
    input wire logic i_converter_enable_input,
    input wire logic i_wake_enable_input,
    input wire logic i_parallel_pin,
    input wire logic i_supply_below,
    input wire logic [19:0] i_boot_straps,
    // control outputs
    output logic o_mute,
    output logic o_bypass,
    output logic [19:0] o_tone_prescale,
    output logic [19:0] o_low_shelf,
    output logic [19:0] o_high_shelf,
    output logic [19:0] o_boot_setting,
    output logic [2:0] o_supply_level_select,
    output logic [3:0] o_converter_clock_select,
    output logic o_converter_clock,
    output logic o_power_good
);

    // whole module state in one record
    typedef struct packed {
        dcr_pkg::dcr_fsm_t fsm; // request sequencer
        logic ready; // request port open
        logic rsp_valid; // answer strobe
        logic [19:0] rsp_data; // answer word
        logic mem_rd; // memory read strobe
        logic [10:0] mem_addr; // memory read address
        logic [19:0] conv_word; // converter control word
        logic [19:0] mute_bypass; // mute and bypass bits
        logic [19:0] boot_shadow; // start-up configuration copy
        logic boot_loaded; // straps captured
        logic [1:0] boot_wait; // settle count after reset
        logic [19:0] prescale; // tone prescale coefficient
        logic [19:0] low_shelf; // bass coefficient
        logic [19:0] high_shelf; // treble coefficient
        logic [1:0] en_meta; // enable synchroniser stage one
        logic [1:0] en_sync; // enable synchroniser stage two
        logic pin_meta; // pin level stage one
        logic pin_sync; // pin level stage two
        logic below_meta; // monitor stage one
        logic below_sync; // monitor stage two
        logic power_good; // supply above threshold
        logic [19:0] strap_meta; // strap stage one
        logic [19:0] strap_sync; // strap stage two
        logic [5:0] div_cnt; // divider count
        logic [3:0] div_code; // code in use by divider
        logic conv_clk; // divided converter clock
    } dcr_state_t;

    localparam dcr_state_t ST_RESET = '{
        fsm: dcr_pkg::FSM_IDLE,
        ready: 1'b0,
        rsp_valid: 1'b0,
        rsp_data: 20'h00000,
        mem_rd: 1'b0,
        mem_addr: 11'h000,
        conv_word: dcr_pkg::RST_CONV_WORD,
        mute_bypass: dcr_pkg::RST_MUTE_BYPASS,
        boot_shadow: 20'h00000,
        boot_loaded: 1'b0,
        boot_wait: 2'h0,
        prescale: dcr_pkg::RST_PRESCALE,
        low_shelf: dcr_pkg::RST_LOW_SHELF,
        high_shelf: dcr_pkg::RST_HIGH_SHELF,
        en_meta: 2'h0,
        en_sync: 2'h0,
        pin_meta: 1'b0,
        pin_sync: 1'b0,
        below_meta: 1'b0,
        below_sync: 1'b0,
        power_good: 1'b0,
        strap_meta: 20'h00000,
        strap_sync: 20'h00000,
        div_cnt: 6'h00,
        div_code: 4'h0,
        conv_clk: 1'b0
    };

    dcr_state_t st_r; // registered state
    dcr_state_t st_nxt; // next state
    logic taken; // request accepted this cycle

    // last count of a half period for a given code
    function automatic logic [5:0] div_limit(input logic [3:0] code);
        div_limit = dcr_pkg::DIV_BASE + {2'h0, code} - 6'h01;
    endfunction

    // register readback; write-only and unknown numbers read zero
    function automatic logic [19:0] reg_read(input logic [7:0] num, input dcr_state_t s);
        case (num)
            dcr_pkg::REG_LOW_SHELF: reg_read = s.low_shelf;
            dcr_pkg::REG_HIGH_SHELF: reg_read = s.high_shelf;
            dcr_pkg::REG_MUTE_BYPASS: reg_read = s.mute_bypass;
            dcr_pkg::REG_PIN_LEVEL: reg_read = {19'h00000, s.pin_sync};
            dcr_pkg::REG_BOOT_SHADOW: reg_read = s.boot_shadow;
            dcr_pkg::REG_PRESCALE: reg_read = s.prescale;
            default: reg_read = 20'h00000;
        endcase
    endfunction

    // a request counts only at an edge where the port already shows open
    assign taken = i_req_valid && st_r.ready;

    // next-state logic
    always_comb begin
        st_nxt = st_r;
        st_nxt.rsp_valid = 1'b0;
        st_nxt.mem_rd = 1'b0;
        // synchronisers: stage one is read only by stage two
        st_nxt.en_meta = {i_converter_enable_input, i_wake_enable_input};
        st_nxt.en_sync = st_r.en_meta;
        st_nxt.pin_meta = i_parallel_pin;
        st_nxt.pin_sync = st_r.pin_meta;
        st_nxt.below_meta = i_supply_below;
        st_nxt.below_sync = st_r.below_meta;
        st_nxt.strap_meta = i_boot_straps;
        st_nxt.strap_sync = st_r.strap_meta;
        // monitor comparator already follows the selected threshold
        st_nxt.power_good = !st_r.below_sync;
        // straps caught once, after the synchroniser has filled
        if (!st_r.boot_loaded) begin
            if (st_r.boot_wait == dcr_pkg::BOOT_WAIT_CYCLES) begin
                st_nxt.boot_shadow = st_r.strap_sync & dcr_pkg::BOOT_VALID_MASK;
                st_nxt.boot_loaded = 1'b1;
            end else begin
                st_nxt.boot_wait = st_r.boot_wait + 2'h1;
            end
        end
        // divider runs regardless of enables so the setting stays live
        if (st_r.div_cnt == div_limit(st_r.div_code)) begin
            st_nxt.div_cnt = 6'h00;
            st_nxt.conv_clk = !st_r.conv_clk;
            // code swap only here, so no half period is cut short
            st_nxt.div_code = st_r.conv_word[dcr_pkg::CLKSEL_MSB:dcr_pkg::CLKSEL_LSB];
        end else begin
            st_nxt.div_cnt = st_r.div_cnt + 6'h01;
        end
        // request sequencer
        case (st_r.fsm)
            dcr_pkg::FSM_IDLE: begin
                if (taken) begin
                    case (i_req_kind)
                        dcr_pkg::CMD_WRITE_REG: begin
                            // unknown numbers fall through silently
                            case (i_req_reg)
                                dcr_pkg::REG_LOW_SHELF: st_nxt.low_shelf = i_req_data;
                                dcr_pkg::REG_HIGH_SHELF: st_nxt.high_shelf = i_req_data;
                                dcr_pkg::REG_CONV_WORD: st_nxt.conv_word = i_req_data;
                                dcr_pkg::REG_MUTE_BYPASS: st_nxt.mute_bypass = i_req_data;
                                dcr_pkg::REG_BOOT_SHADOW: st_nxt.boot_shadow = i_req_data;
                                dcr_pkg::REG_PRESCALE: st_nxt.prescale = i_req_data;
                                default: st_nxt.rsp_valid = 1'b0;
                            endcase
                        end
                        dcr_pkg::CMD_READ_REG: begin
                            st_nxt.rsp_valid = 1'b1;
                            st_nxt.rsp_data = reg_read(i_req_reg, st_r);
                        end
                        dcr_pkg::CMD_DEFAULT_READ: begin
                            // no address phase: counter answered at once
                            st_nxt.rsp_valid = 1'b1;
                            st_nxt.rsp_data = {4'h0, i_frame_count};
                        end
                        dcr_pkg::CMD_READ_D1: begin
                            st_nxt.mem_rd = 1'b1;
                            st_nxt.mem_addr = i_req_mem_addr;
                            st_nxt.fsm = dcr_pkg::FSM_ISSUE;
                        end
                        default: st_nxt.fsm = dcr_pkg::FSM_IDLE; // other kinds ignored
                    endcase
                end
            end
            dcr_pkg::FSM_ISSUE: begin
                // memory answers one cycle after its strobe
                st_nxt.fsm = dcr_pkg::FSM_CATCH;
            end
            dcr_pkg::FSM_CATCH: begin
                st_nxt.rsp_valid = 1'b1;
                st_nxt.rsp_data = i_mem_data;
                st_nxt.fsm = dcr_pkg::FSM_IDLE;
            end
            default: st_nxt.fsm = dcr_pkg::FSM_IDLE;
        endcase
        // port closed while either enable is low; state is kept
        // ready follows the synced enables in step, so no write slips in after a drop
        st_nxt.ready = (st_nxt.fsm == dcr_pkg::FSM_IDLE) && (&st_nxt.en_sync);
    end

    // state register
    always_ff @(posedge i_clock or negedge i_rst_b) begin
        if (!i_rst_b) begin
            st_r <= ST_RESET;
        end else begin
            st_r <= st_nxt;
        end
    end

    // outputs straight from the state register
    assign o_ready = st_r.ready;
    assign o_rsp_valid = st_r.rsp_valid;
    assign o_rsp_data = st_r.rsp_data;
    assign o_mem_rd = st_r.mem_rd;
    assign o_mem_addr = st_r.mem_addr;
    assign o_mute = st_r.mute_bypass[dcr_pkg::MUTE_BIT];
    assign o_bypass = st_r.mute_bypass[dcr_pkg::BYPASS_BIT];
    assign o_tone_prescale = st_r.prescale;
    assign o_low_shelf = st_r.low_shelf;
    assign o_high_shelf = st_r.high_shelf;
    assign o_boot_setting = st_r.boot_shadow;
    assign o_supply_level_select = st_r.conv_word[dcr_pkg::SUPPLY_MSB:dcr_pkg::SUPPLY_LSB];
    assign o_converter_clock_select = st_r.conv_word[dcr_pkg::CLKSEL_MSB:dcr_pkg::CLKSEL_LSB];
    assign o_converter_clock = st_r.conv_clk;
    assign o_power_good = st_r.power_good;

    // checks on the register set
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_b);

    default_read_a: assert property (
        taken && i_req_kind == dcr_pkg::CMD_DEFAULT_READ
        |=> o_rsp_valid && o_rsp_data == {4'h0, $past(i_frame_count)})
        else $error("default read did not return frame counter");

    mem_read_a: assert property (
        taken && i_req_kind == dcr_pkg::CMD_READ_D1
        |=> o_mem_rd && o_mem_addr == $past(i_req_mem_addr) && !o_ready
        ##1 !o_mem_rd && !o_rsp_valid ##1 o_rsp_valid && o_rsp_data == $past(i_mem_data))
        else $error("memory read sequence wrong");

    enable_gate_a: assert property (
        !(&st_r.en_sync) |-> !o_ready)
        else $error("port open while enables low");

    conv_keep_a: assert property (
        !(&st_r.en_sync) |=> $stable(st_r.conv_word))
        else $error("converter word changed while disabled");

    supply_write_a: assert property (
        taken && i_req_kind == dcr_pkg::CMD_WRITE_REG && i_req_reg == dcr_pkg::REG_CONV_WORD
        |=> o_supply_level_select == $past(i_req_data[dcr_pkg::SUPPLY_MSB:dcr_pkg::SUPPLY_LSB]))
        else $error("supply level not taken from write");

    mute_bits_a: assert property (
        taken && i_req_kind == dcr_pkg::CMD_WRITE_REG && i_req_reg == dcr_pkg::REG_MUTE_BYPASS
        |=> o_mute == $past(i_req_data[dcr_pkg::MUTE_BIT])
        && o_bypass == $past(i_req_data[dcr_pkg::BYPASS_BIT]))
        else $error("mute or bypass bit not applied");

    prescale_read_a: assert property (
        taken && i_req_kind == dcr_pkg::CMD_READ_REG && i_req_reg == dcr_pkg::REG_PRESCALE
        |=> o_rsp_valid && o_rsp_data == $past(o_tone_prescale))
        else $error("prescale readback mismatch");

    pin_read_a: assert property (
        taken && i_req_kind == dcr_pkg::CMD_READ_REG && i_req_reg == dcr_pkg::REG_PIN_LEVEL
        |=> o_rsp_data == {19'h00000, $past(st_r.pin_sync)})
        else $error("pin level readback mismatch");

    wo_read_a: assert property (
        taken && i_req_kind == dcr_pkg::CMD_READ_REG && i_req_reg == dcr_pkg::REG_CONV_WORD
        |=> o_rsp_data == 20'h00000 && $stable(st_r.conv_word))
        else $error("converter word read misbehaved");

    div_toggle_a: assert property (
        st_r.div_cnt == div_limit(st_r.div_code) |=> $changed(o_converter_clock))
        else $error("divider did not toggle at limit");

    code_swap_a: assert property (
        $changed(st_r.div_code) |-> st_r.div_cnt == 6'h00 && $changed(o_converter_clock))
        else $error("clock code changed mid period");

    // landing checks: coefficients, straps, read-only numbers, supply monitor
    low_shelf_write_a: assert property (
        taken && i_req_kind == dcr_pkg::CMD_WRITE_REG && i_req_reg == dcr_pkg::REG_LOW_SHELF
        |=> o_low_shelf == $past(i_req_data))
        else $error("low shelf write not stored");

    high_shelf_write_a: assert property (
        taken && i_req_kind == dcr_pkg::CMD_WRITE_REG && i_req_reg == dcr_pkg::REG_HIGH_SHELF
        |=> o_high_shelf == $past(i_req_data))
        else $error("high shelf write not stored");

    ro_write_a: assert property (
        taken && i_req_kind == dcr_pkg::CMD_WRITE_REG && i_req_reg == dcr_pkg::REG_PIN_LEVEL
        |=> $stable(st_r.conv_word) && $stable(st_r.mute_bypass) && $stable(st_r.prescale))
        else $error("read-only write disturbed a register");

    // the strap copy is judged only without a same-cycle write, which wins
    boot_load_a: assert property (
        !st_r.boot_loaded && st_r.boot_wait == dcr_pkg::BOOT_WAIT_CYCLES && !taken
        |=> o_boot_setting == ($past(st_r.strap_sync) & dcr_pkg::BOOT_VALID_MASK))
        else $error("straps not copied into boot shadow");

    // thresholds are analog; only the synced comparator level is judged here
    power_good_a: assert property (
        st_r.below_sync |=> !o_power_good)
        else $error("power good held while supply low");

    // main scenarios
    cov_d1_c: cover property (taken && i_req_kind == dcr_pkg::CMD_READ_D1 ##3 o_rsp_valid);
    cov_poll_c: cover property (
        taken && i_req_kind == dcr_pkg::CMD_DEFAULT_READ
        ##1 taken && i_req_kind == dcr_pkg::CMD_DEFAULT_READ);
    cov_swap_c: cover property ($changed(st_r.div_code) && st_r.div_code != 4'h0);
    cov_off_c: cover property (o_ready ##1 !o_ready && !(&st_r.en_sync));
    cov_mute_c: cover property (o_mute ##1 !o_mute && o_bypass);

endmodule

// ### core/dcr_pkg.sv
// constants and encodings for the decoder control register set
package dcr_pkg;
    // register numbers as carried in the register commands
    localparam logic [7:0] REG_LOW_SHELF = 8'h6b;
    localparam logic [7:0] REG_HIGH_SHELF = 8'h6f;
    localparam logic [7:0] REG_CONV_WORD = 8'h8e;
    localparam logic [7:0] REG_MUTE_BYPASS = 8'haa;
    localparam logic [7:0] REG_PIN_LEVEL = 8'hc8;
    localparam logic [7:0] REG_BOOT_SHADOW = 8'he6;
    localparam logic [7:0] REG_PRESCALE = 8'he7;

    // values after reset
    localparam logic [19:0] RST_LOW_SHELF = 20'h00000;
    localparam logic [19:0] RST_HIGH_SHELF = 20'h00000;
    localparam logic [19:0] RST_CONV_WORD = 20'h08000;
    localparam logic [19:0] RST_MUTE_BYPASS = 20'h00000;
    localparam logic [19:0] RST_PRESCALE = 20'h80000;

    // field positions
    localparam int MUTE_BIT = 0;
    localparam int BYPASS_BIT = 1;
    localparam int SUPPLY_LSB = 14;
    localparam int SUPPLY_MSB = 16;
    localparam int CLKSEL_LSB = 10;
    localparam int CLKSEL_MSB = 13;
    localparam int PIN_BIT = 0;

    // boot shadow: only bits 8 and 4..0 carry meaning
    localparam logic [19:0] BOOT_VALID_MASK = 20'h0011f;
    // edges after reset release before the straps are trusted
    localparam logic [1:0] BOOT_WAIT_CYCLES = 2'h2;

    // converter clock divider: half period is base plus the select code, quotient twice that
    localparam logic [5:0] DIV_BASE = 6'h20;

    // command kinds on the request port
    localparam logic [3:0] CMD_WRITE_REG = 4'h9;
    localparam logic [3:0] CMD_READ_REG = 4'hd;
    localparam logic [3:0] CMD_READ_D1 = 4'hf;
    localparam logic [3:0] CMD_DEFAULT_READ = 4'h7;

    // request sequencer states, one-hot
    typedef enum logic [2:0] {
        FSM_IDLE = 3'b001,
        FSM_ISSUE = 3'b010,
        FSM_CATCH = 3'b100
    } dcr_fsm_t;
endpackage

// ### test/dcr_core_tb.sv
// self-checking bench for the decoder control register set
`timescale 1ns/1ps
module dcr_core_tb;
    // stimulus
    logic i_clock, i_rst_b, i_req_valid, i_parallel_pin, i_supply_below;
    logic i_converter_enable_input, i_wake_enable_input;
    logic [3:0] i_req_kind;
    logic [7:0] i_req_reg;
    logic [10:0] i_req_mem_addr, o_mem_addr;
    logic [19:0] i_req_data, i_mem_data, i_boot_straps;
    logic [15:0] i_frame_count;
    // observed
    logic o_ready, o_rsp_valid, o_mem_rd, o_mute, o_bypass, o_converter_clock, o_power_good;
    logic [19:0] o_rsp_data, o_tone_prescale, o_low_shelf, o_high_shelf, o_boot_setting;
    logic [2:0] o_supply_level_select;
    logic [3:0] o_converter_clock_select;
    // bookkeeping
    int miscompares, cmp_count, cycles;
    logic [19:0] rd_val;

    dcr_core dut_u (.i_clock, .i_rst_b, .i_req_valid, .i_req_kind, .i_req_reg,
        .i_req_mem_addr, .i_req_data, .o_ready, .o_rsp_valid, .o_rsp_data, .o_mem_rd,
        .o_mem_addr, .i_mem_data, .i_frame_count, .i_converter_enable_input,
        .i_wake_enable_input, .i_parallel_pin, .i_supply_below, .i_boot_straps, .o_mute,
        .o_bypass, .o_tone_prescale, .o_low_shelf, .o_high_shelf, .o_boot_setting,
        .o_supply_level_select, .o_converter_clock_select, .o_converter_clock,
        .o_power_good);

    dcr_mem_model mem_u (.i_clock(i_clock), .i_mem_rd(o_mem_rd), .i_mem_addr(o_mem_addr),
        .o_mem_data(i_mem_data));

    // 100 ns clock
    initial begin
        i_clock = 1'b0;
        forever #50 i_clock = ~i_clock;
    end

    // cycle count doubles as timebase and hang guard
    always @(posedge i_clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (miscompares == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    // request held from a falling edge until a rising edge sees ready
    task automatic req(input logic [3:0] k, input logic [7:0] r, input logic [10:0] a,
        input logic [19:0] d);
        int n;
        n = 0;
        @(negedge i_clock);
        i_req_valid = 1'b1;
        i_req_kind = k;
        i_req_reg = r;
        i_req_mem_addr = a;
        i_req_data = d;
        while (o_ready !== 1'b1 && n < 40) begin
            n++;
            @(negedge i_clock);
        end
        chk("ready", 20'h1, {19'h0, o_ready});
        @(negedge i_clock);
        i_req_valid = 1'b0;
    endtask

    // any read kind; bounded wait on the answer strobe
    task automatic rd(input logic [3:0] k, input logic [7:0] r, input logic [10:0] a);
        int n;
        n = 0;
        req(k, r, a, 20'h0);
        while (o_rsp_valid !== 1'b1 && n < 5) begin
            n++;
            @(negedge i_clock);
        end
        chk("answer", 20'h1, {19'h0, o_rsp_valid});
        rd_val = o_rsp_data;
    endtask

    task automatic rchk(input string what, input logic [7:0] r, input logic [19:0] exp);
        rd(4'hd, r, 11'h000);
        chk(what, exp, rd_val);
    endtask

    task automatic wr(input logic [7:0] r, input logic [19:0] d);
        req(4'h9, r, 11'h000, d);
        @(negedge i_clock);
    endtask

    // cycle stamp of the next divider output change
    task automatic toggle(output int at);
        int n;
        logic lvl;
        n = 0;
        lvl = o_converter_clock;
        while (o_converter_clock === lvl && n < 100) begin
            n++;
            @(negedge i_clock);
        end
        at = cycles;
    endtask

    task automatic t_reset();
        rchk("low_shelf", 8'h6b, 20'h00000);
        rchk("high_shelf", 8'h6f, 20'h00000);
        rchk("mute_bypass", 8'haa, 20'h00000);
        rchk("prescale", 8'he7, 20'h80000);
        chk("supply_sel", 20'h2, {17'h0, o_supply_level_select});
        chk("clock_sel", 20'h0, {16'h0, o_converter_clock_select});
    endtask

    task automatic t_coeffs();
        wr(8'h6b, 20'h61800);
        wr(8'h6f, 20'h5f800);
        wr(8'he7, 20'he9400);
        rchk("low_shelf", 8'h6b, 20'h61800);
        rchk("high_shelf", 8'h6f, 20'h5f800);
        rchk("prescale", 8'he7, 20'he9400);
        chk("low_out", 20'h61800, o_low_shelf);
        chk("high_out", 20'h5f800, o_high_shelf);
        chk("pre_out", 20'he9400, o_tone_prescale);
    endtask

    task automatic t_mute();
        wr(8'haa, 20'h00001);
        chk("mute", 20'h1, {19'h0, o_mute});
        chk("bypass", 20'h0, {19'h0, o_bypass});
        wr(8'haa, 20'h00002);
        chk("mute", 20'h0, {19'h0, o_mute});
        chk("bypass", 20'h1, {19'h0, o_bypass});
        rchk("mute_bypass", 8'haa, 20'h00002);
        wr(8'haa, 20'h00000);
        chk("bypass", 20'h0, {19'h0, o_bypass});
    endtask

    task automatic t_misc();
        i_parallel_pin = 1'b1;
        wr(8'hc8, 20'hffffe);
        rchk("pin_level", 8'hc8, 20'h00001);
        i_parallel_pin = 1'b0;
        wr(8'h12, 20'h12345);
        req(4'h3, 8'h6b, 11'h000, 20'h00000);
        rchk("pin_level", 8'hc8, 20'h00000);
        rchk("low_shelf", 8'h6b, 20'h61800);
        wr(8'he6, 20'h00105);
        rchk("boot_shadow", 8'he6, 20'h00105);
        chk("boot_out", 20'h00105, o_boot_setting);
    endtask

    task automatic t_conv();
        int a, b, c, d;
        toggle(a);
        toggle(b);
        chk("half_n0", 20'h20, 20'(b - a));
        wr(8'h8e, 20'h1d400);
        toggle(c);
        chk("half_cut", 20'h20, 20'(c - b));
        toggle(d);
        chk("half_n5", 20'h25, 20'(d - c));
        chk("supply_sel", 20'h7, {17'h0, o_supply_level_select});
        chk("clock_sel", 20'h5, {16'h0, o_converter_clock_select});
        rchk("conv_word", 8'h8e, 20'h00000);
        chk("clock_sel", 20'h5, {16'h0, o_converter_clock_select});
    endtask

    task automatic t_mem_dflt();
        rd(4'hf, 8'h00, 11'h7ff);
        chk("mem_word", 20'h5a5a5 ^ 20'h007ff, rd_val);
        rd(4'hf, 8'h00, 11'h001);
        chk("mem_word", 20'h5a5a5 ^ 20'h00001, rd_val);
        i_frame_count = 16'hbeef;
        rd(4'h7, 8'h00, 11'h000);
        chk("frame", 20'h0beef, rd_val);
        i_frame_count = 16'hbef0;
        rd(4'h7, 8'h00, 11'h000);
        chk("frame", 20'h0bef0, rd_val);
    endtask

    task automatic t_enables();
        i_wake_enable_input = 1'b0;
        repeat (4) @(negedge i_clock);
        chk("ready_off", 20'h0, {19'h0, o_ready});
        i_req_valid = 1'b1;
        i_req_kind = 4'h9;
        // aimed at the converter word, so a slipped write would move the supply field
        i_req_reg = 8'h8e;
        i_req_data = 20'h00000;
        repeat (3) @(negedge i_clock);
        i_req_valid = 1'b0;
        chk("supply_kept", 20'h7, {17'h0, o_supply_level_select});
        i_wake_enable_input = 1'b1;
        rchk("low_shelf", 8'h6b, 20'h61800);
        chk("clock_kept", 20'h5, {16'h0, o_converter_clock_select});
        // the other enable closes the port just the same
        i_converter_enable_input = 1'b0;
        repeat (4) @(negedge i_clock);
        chk("ready_off", 20'h0, {19'h0, o_ready});
        i_converter_enable_input = 1'b1;
        rchk("high_shelf", 8'h6f, 20'h5f800);
        chk("supply_kept", 20'h7, {17'h0, o_supply_level_select});
    endtask

    task automatic t_power();
        i_supply_below = 1'b1;
        repeat (4) @(negedge i_clock);
        chk("power_good", 20'h0, {19'h0, o_power_good});
        i_supply_below = 1'b0;
        repeat (4) @(negedge i_clock);
        chk("power_good", 20'h1, {19'h0, o_power_good});
    endtask

    // main sequence
    initial begin
        i_rst_b = 1'b0;
        i_req_valid = 1'b0;
        i_req_kind = 4'h0;
        i_req_reg = 8'h00;
        i_req_mem_addr = 11'h000;
        i_req_data = 20'h00000;
        i_frame_count = 16'h0000;
        i_converter_enable_input = 1'b1;
        i_wake_enable_input = 1'b1;
        i_parallel_pin = 1'b0;
        i_supply_below = 1'b0;
        i_boot_straps = 20'hfffff;
        repeat (6) @(negedge i_clock);
        i_rst_b = 1'b1;
        repeat (6) @(negedge i_clock);
        chk("boot_straps", 20'h0011f, o_boot_setting);
        t_reset();
        t_coeffs();
        t_mute();
        t_misc();
        t_conv();
        t_mem_dflt();
        t_enables();
        t_power();
        end_of_test();
    end
endmodule

// ### test/dcr_mem_model.sv
// second data memory stand-in answering the block's read strobe
`timescale 1ns/1ps
module dcr_mem_model (
    // clock
    input wire logic i_clock,
    // read port from the block
    input wire logic i_mem_rd,
    input wire logic [10:0] i_mem_addr,
    output logic [19:0] o_mem_data
);
    // known start so the scramble below never sits at x
    initial o_mem_data = 20'h00000;
    // word holds one cycle after the strobe, then flips so stale data shows
    always @(posedge i_clock) begin
        if (i_mem_rd) begin
            o_mem_data <= {9'h000, i_mem_addr} ^ 20'h5a5a5;
        end else begin
            o_mem_data <= ~o_mem_data;
        end
    end
endmodule
